// ===== shared/gate_cmd_cfg.svh
// constants for the gate and switching port command handler
// assumes one 100 MHz clock, an apb register slave and a byte wide host link
// How it works
// RULE1 - open command starts decoding; gate stays open until a closing cause occurs
// RULE2 - close command stops decoding, closes the gate, then sends the read result
// RULE3 - a manually closed gate always reports the no-read result
// RULE4 - activate command takes port 1 or 2 and drives it logic high
// RULE5 - host activates only ports already configured as switching outputs
// RULE6 - commands and queries use logic states; inversion turns logic high into 0V
// RULE7 - query returns 0, 1, I or P per port, from command-set states
// RULE8 - set command writes 0 or 1 per listed port; non-output ports ignored
// RULE9 - host may list some ports, but always in ascending order
// RULE10 - set command replies with status 00, 01, 02 or 03
// RULE11 - activate, and close with the gate already shut, send no reply; malformed ones change nothing
`ifndef GATE_CMD_CFG_SVH
`define GATE_CMD_CFG_SVH

// register byte offsets
`define GC_CFG_OFS 8'h00
`define GC_STAT_OFS 8'h04
`define GC_CFG_RESET 32'h0000_0000

// config field positions: two mode bits per port, then one invert bit per port
`define GC_MODE_POS 0
`define GC_INV_POS 4
// status field positions
`define GC_ST_GATE_POS 0
`define GC_ST_LOGIC_POS 1
`define GC_ST_PIN_POS 3

// buffer sizes
`define GC_CMD_MAX 12
`define GC_TX_MAX 13

// characters
`define GC_CH_CR 8'h0D
`define GC_CH_O 8'h4F
`define GC_CH_A 8'h41
`define GC_CH_S 8'h53
`define GC_CH_I 8'h49
`define GC_CH_P 8'h50
`define GC_CH_QM 8'h3F
`define GC_CH_SP 8'h20
`define GC_CH_EQ 8'h3D
`define GC_CH_SEMI 8'h3B
`define GC_CH_PLUS 8'h2B
`define GC_CH_MINUS 8'h2D
`define GC_CH_0 8'h30
`define GC_CH_1 8'h31
`define GC_CH_2 8'h32
`define GC_CH_3 8'h33
`define GC_NO_READ_CHAR 8'h3F

`endif

// ===== shared/gate_cmd_pkg.sv
// types for the gate and switching port command handler
// assumes gate_cmd_cfg.svh holds all numeric constants
package gate_cmd_pkg;

    typedef enum logic [2:0] {
        ST_IDLE = 3'h1,
        ST_EXEC = 3'h2,
        ST_SEND = 3'h4
    } ctrl_state_t;

    typedef enum logic [1:0] {
        MODE_PASSIVE = 2'h0,
        MODE_INPUT = 2'h1,
        MODE_OUTPUT = 2'h2
    } port_mode_t;

    typedef enum logic [2:0] {
        ACT_NONE = 3'h0,
        ACT_OPEN = 3'h1,
        ACT_CLOSE = 3'h2,
        ACT_ACTIVATE = 3'h3,
        ACT_QUERY = 3'h4,
        ACT_SET = 3'h5
    } cmd_act_t;

endpackage : gate_cmd_pkg

// ===== verilog/switch_port.sv
// one configurable switching port: mode, inversion, logic state and pin drive
// assumes mode and invert come from the register file of the command handler
`timescale 1ns/10ps
`include "gate_cmd_cfg.svh"
module switch_port (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // configuration
    input wire logic [1:0] mode_i,
    input wire logic invert_i,
    // state write
    input wire logic set_i,
    input wire logic value_i,
    // pin
    input wire logic pin_i,
    output logic pin_o,
    output logic pin_oe_n_o,
    // state view
    output logic logic_o,
    output logic in_level_o
);
    logic is_output;
    logic state;

    assign is_output = (mode_i == gate_cmd_pkg::MODE_OUTPUT);

    // writes to a port that is not an output are dropped [RULE8]
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state <= 1'b0;
        end else if (set_i && is_output) begin
            state <= value_i;
        end
    end

    // pin level is the logic state after inversion [RULE6]
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pin_o <= 1'b0;
            pin_oe_n_o <= 1'b1;
            logic_o <= 1'b0;
            in_level_o <= 1'b0;
        end else begin
            pin_o <= state ^ invert_i;
            pin_oe_n_o <= ~is_output;
            logic_o <= state;
            in_level_o <= pin_i ^ invert_i;
        end
    end
endmodule : switch_port

// ===== verilog/gate_and_output_command_handler.sv
// host command interpreter for the read gate and the two switching ports
// assumes host bytes arrive synchronous to mclk_i, each command ends in CR,
// and the decoding engine reports its own closing causes as one-cycle pulses
`timescale 1ns/10ps
`include "gate_cmd_cfg.svh"
module gate_and_output_command_handler (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // apb slave
    input wire logic [7:0] paddr_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // host receive stream
    input wire logic [7:0] rx_data_i,
    input wire logic rx_valid_i,
    output logic rx_ready_o,
    // host transmit stream
    input wire logic tx_ready_i,
    output logic [7:0] tx_data_o,
    output logic tx_valid_o,
    // decoding engine
    input wire logic quality_met_i,
    input wire logic timeout_i,
    input wire logic scan_limit_i,
    output logic decode_en_o,
    output logic no_read_result_o,
    // switching ports, index 0 is switch_port_one
    input wire logic [1:0] pin_i,
    output logic [1:0] pin_o,
    output logic [1:0] pin_oe_n_o
);
    gate_cmd_pkg::ctrl_state_t state;
    logic [31:0] cfg;
    logic [7:0] cmd_buf [0:`GC_CMD_MAX-1];
    logic [3:0] cmd_len;
    logic cmd_ovf;
    logic [7:0] tx_buf [0:`GC_TX_MAX-1];
    logic [3:0] tx_len;
    logic [3:0] tx_idx;
    logic [1:0] port_logic;
    logic [1:0] port_in;
    logic [1:0] in_prev;
    logic [1:0] port_set;
    logic [1:0] port_val;
    logic rx_take;
    logic cr_seen;
    logic apb_setup;
    logic apb_write;
    logic switch_close;
    gate_cmd_pkg::cmd_act_t act;
    logic [1:0] act_mask;
    logic [1:0] act_val;
    logic [7:0] act_status;

    assign rx_take = rx_valid_i && rx_ready_o;
    assign cr_seen = rx_take && (rx_data_i == `GC_CH_CR);
    assign apb_setup = psel_i && !penable_i;
    assign apb_write = psel_i && penable_i && pready_o && pwrite_i;

    // checks one "Sn=v" field; returns 00, 01 or 02 as a status digit
    function automatic logic [7:0] field_check(input logic [7:0] s, input logic [7:0] n,
                                               input logic [7:0] eq, input logic [7:0] v);
        logic [7:0] res;
        res = `GC_CH_0;
        if (s != `GC_CH_S || eq != `GC_CH_EQ) begin
            res = `GC_CH_1;
        end else if ((n != `GC_CH_1 && n != `GC_CH_2) || (v != `GC_CH_0 && v != `GC_CH_1)) begin
            res = `GC_CH_2;
        end
        return res;
    endfunction : field_check

    // command decode from the collected line
    always_comb begin
        logic [7:0] st_a;
        logic [7:0] st_b;
        logic is_oa;
        st_a = `GC_CH_0;
        st_b = `GC_CH_0;
        act = gate_cmd_pkg::ACT_NONE;
        act_mask = 2'h0;
        act_val = 2'h0;
        act_status = `GC_CH_0;
        is_oa = (cmd_len >= 4'h3) && (cmd_buf[0] == `GC_CH_O) && (cmd_buf[1] == `GC_CH_A);
        if (!cmd_ovf && cmd_len == 4'h1 && cmd_buf[0] == `GC_CH_PLUS) begin
            act = gate_cmd_pkg::ACT_OPEN; // [RULE1]
        end else if (!cmd_ovf && cmd_len == 4'h1 && cmd_buf[0] == `GC_CH_MINUS) begin
            act = gate_cmd_pkg::ACT_CLOSE; // [RULE2]
        end else if (is_oa && cmd_buf[2] == `GC_CH_SP) begin
            act = gate_cmd_pkg::ACT_SET; // [RULE10]
            if (cmd_ovf) begin
                act_status = `GC_CH_3;
            end else if (cmd_len == 4'h7) begin
                act_status = field_check(cmd_buf[3], cmd_buf[4], cmd_buf[5], cmd_buf[6]);
                act_mask[cmd_buf[4][1]] = 1'b1;
                act_val[cmd_buf[4][1]] = cmd_buf[6][0];
            end else if (cmd_len == 4'hC) begin
                st_a = field_check(cmd_buf[3], cmd_buf[4], cmd_buf[5], cmd_buf[6]);
                st_b = field_check(cmd_buf[8], cmd_buf[9], cmd_buf[10], cmd_buf[11]);
                // two fields must be S1 then S2; any other order is a syntax error unless a field is out of range, which gives 02
                if (cmd_buf[7] != `GC_CH_SEMI || st_a == `GC_CH_1 || st_b == `GC_CH_1) begin
                    act_status = `GC_CH_1;
                end else if (st_a == `GC_CH_2 || st_b == `GC_CH_2) begin
                    act_status = `GC_CH_2;
                end else if (cmd_buf[4] != `GC_CH_1 || cmd_buf[9] != `GC_CH_2) begin
                    act_status = `GC_CH_1; // [RULE9]
                end
                act_mask = 2'h3;
                act_val = {cmd_buf[11][0], cmd_buf[6][0]};
            end else begin
                act_status = `GC_CH_1;
            end
            if (act_status != `GC_CH_0) begin
                act_mask = 2'h0;
            end
        end else if (is_oa && !cmd_ovf && cmd_len == 4'h3) begin
            if (cmd_buf[2] == `GC_CH_QM) begin
                act = gate_cmd_pkg::ACT_QUERY; // [RULE7]
            end else if (cmd_buf[2] == `GC_CH_1 || cmd_buf[2] == `GC_CH_2) begin
                act = gate_cmd_pkg::ACT_ACTIVATE; // [RULE4]
                act_mask[cmd_buf[2][1]] = 1'b1;
                act_val = 2'h3;
            end
        end
        // anything else, such as a bad port index, is dropped silently [RULE11]
    end

    // query code for one port
    function automatic logic [7:0] port_code(input logic [1:0] mode, input logic lvl);
        logic [7:0] res;
        res = `GC_CH_P;
        if (mode == gate_cmd_pkg::MODE_OUTPUT) begin
            res = lvl ? `GC_CH_1 : `GC_CH_0;
        end else if (mode == gate_cmd_pkg::MODE_INPUT) begin
            res = `GC_CH_I;
        end
        return res;
    endfunction : port_code

    // line collection; overlong lines are flagged, not wrapped
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cmd_len <= 4'h0;
            cmd_ovf <= 1'b0;
        end else if (state == gate_cmd_pkg::ST_EXEC) begin
            cmd_len <= 4'h0;
            cmd_ovf <= 1'b0;
        end else if (rx_take && !cr_seen) begin
            if (cmd_len == 4'(`GC_CMD_MAX)) begin
                cmd_ovf <= 1'b1;
            end else begin
                cmd_buf[cmd_len] <= rx_data_i;
                cmd_len <= cmd_len + 4'h1;
            end
        end
    end

    // sequencer; receive is held off while a reply goes out, so no line is lost
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            state <= gate_cmd_pkg::ST_IDLE;
            rx_ready_o <= 1'b1;
        end else begin
            case (state)
                gate_cmd_pkg::ST_IDLE: begin
                    if (cr_seen) begin
                        state <= gate_cmd_pkg::ST_EXEC;
                        rx_ready_o <= 1'b0;
                    end
                end
                gate_cmd_pkg::ST_EXEC: begin
                    if (act == gate_cmd_pkg::ACT_QUERY || act == gate_cmd_pkg::ACT_SET ||
                        (act == gate_cmd_pkg::ACT_CLOSE && decode_en_o)) begin
                        state <= gate_cmd_pkg::ST_SEND;
                    end else begin
                        state <= gate_cmd_pkg::ST_IDLE;
                        rx_ready_o <= 1'b1;
                    end
                end
                gate_cmd_pkg::ST_SEND: begin
                    if (tx_valid_o && tx_ready_i && tx_idx == tx_len - 4'h1) begin
                        state <= gate_cmd_pkg::ST_IDLE;
                        rx_ready_o <= 1'b1;
                    end
                end
                default: begin
                    state <= gate_cmd_pkg::ST_IDLE;
                    rx_ready_o <= 1'b1;
                end
            endcase
        end
    end

    // reply framing
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            tx_len <= 4'h0;
        end else if (state == gate_cmd_pkg::ST_EXEC) begin
            tx_buf[0] <= `GC_CH_O;
            tx_buf[1] <= `GC_CH_A;
            if (act == gate_cmd_pkg::ACT_QUERY) begin
                tx_buf[2] <= `GC_CH_SP;
                tx_buf[3] <= `GC_CH_S;
                tx_buf[4] <= `GC_CH_1;
                tx_buf[5] <= `GC_CH_EQ;
                tx_buf[6] <= port_code(cfg[`GC_MODE_POS +: 2], port_logic[0]); // [RULE7]
                tx_buf[7] <= `GC_CH_SEMI;
                tx_buf[8] <= `GC_CH_S;
                tx_buf[9] <= `GC_CH_2;
                tx_buf[10] <= `GC_CH_EQ;
                tx_buf[11] <= port_code(cfg[`GC_MODE_POS + 2 +: 2], port_logic[1]); // [RULE7]
                tx_buf[12] <= `GC_CH_CR;
                tx_len <= 4'hD;
            end else if (act == gate_cmd_pkg::ACT_SET) begin
                tx_buf[2] <= `GC_CH_EQ;
                tx_buf[3] <= `GC_CH_0;
                tx_buf[4] <= act_status; // [RULE10]
                tx_buf[5] <= `GC_CH_CR;
                tx_len <= 4'h6;
            end else begin
                // manual close reports no-read, since no read criterion could be met [RULE3]
                tx_buf[0] <= `GC_NO_READ_CHAR;
                tx_buf[1] <= `GC_CH_CR;
                tx_len <= 4'h2;
            end
        end
    end

    // byte output
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            tx_idx <= 4'h0;
            tx_valid_o <= 1'b0;
            tx_data_o <= 8'h00;
        end else if (state == gate_cmd_pkg::ST_EXEC) begin
            tx_idx <= 4'h0;
            tx_valid_o <= 1'b0;
        end else if (state == gate_cmd_pkg::ST_SEND) begin
            if (!tx_valid_o) begin
                tx_valid_o <= 1'b1;
                tx_data_o <= tx_buf[tx_idx];
            end else if (tx_ready_i) begin
                if (tx_idx == tx_len - 4'h1) begin
                    tx_valid_o <= 1'b0;
                end else begin
                    tx_data_o <= tx_buf[tx_idx + 4'h1];
                end
                tx_idx <= tx_idx + 4'h1;
            end
        end
    end

    // a rising logic level on a port configured as input closes the gate
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            in_prev <= 2'h0;
        end else begin
            in_prev <= port_in;
        end
    end

    always_comb begin
        switch_close = 1'b0;
        for (int i = 0; i < 2; i++) begin
            if (cfg[`GC_MODE_POS + 2 * i +: 2] == gate_cmd_pkg::MODE_INPUT &&
                port_in[i] && !in_prev[i]) begin
                switch_close = 1'b1;
            end
        end
    end

    // read gate; a later close cause only ends decoding, the engine reports its own result
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            decode_en_o <= 1'b0;
            no_read_result_o <= 1'b0;
        end else begin
            no_read_result_o <= 1'b0;
            if (state == gate_cmd_pkg::ST_EXEC && act == gate_cmd_pkg::ACT_OPEN) begin
                decode_en_o <= 1'b1; // [RULE1]
            end else if (state == gate_cmd_pkg::ST_EXEC && act == gate_cmd_pkg::ACT_CLOSE) begin
                decode_en_o <= 1'b0; // [RULE2]
                no_read_result_o <= decode_en_o; // [RULE3]
            end else if (quality_met_i || timeout_i || scan_limit_i || switch_close) begin
                decode_en_o <= 1'b0; // [RULE1]
            end
        end
    end

    // port writes; activation of a non-output port is dropped inside the port [RULE5]
    assign port_set = (state == gate_cmd_pkg::ST_EXEC) ? act_mask : 2'h0; // [RULE8]
    assign port_val = act_val;

    generate
        for (genvar g = 0; g < 2; g++) begin : g_port
            switch_port u_port (
                .mclk_i(mclk_i),
                .reset_i(reset_i),
                .mode_i(cfg[`GC_MODE_POS + 2 * g +: 2]),
                .invert_i(cfg[`GC_INV_POS + g]),
                .set_i(port_set[g]),
                .value_i(port_val[g]),
                .pin_i(pin_i[g]),
                .pin_o(pin_o[g]),
                .pin_oe_n_o(pin_oe_n_o[g]),
                .logic_o(port_logic[g]),
                .in_level_o(port_in[g])
            );
        end
    endgenerate

    // apb: answer one cycle after setup, so pready and read data come from flops
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
            prdata_o <= 32'h0000_0000;
        end else if (apb_setup) begin
            pready_o <= 1'b1;
            pslverr_o <= (paddr_i != `GC_CFG_OFS) && (paddr_i != `GC_STAT_OFS);
            prdata_o <= 32'h0000_0000;
            if (!pwrite_i && paddr_i == `GC_CFG_OFS) begin
                prdata_o <= cfg;
            end else if (!pwrite_i && paddr_i == `GC_STAT_OFS) begin
                prdata_o[`GC_ST_GATE_POS] <= decode_en_o;
                prdata_o[`GC_ST_LOGIC_POS +: 2] <= port_logic;
                prdata_o[`GC_ST_PIN_POS +: 2] <= pin_o;
            end
        end else begin
            pready_o <= 1'b0;
            pslverr_o <= 1'b0;
        end
    end

    // only the six defined config bits are writable
    always_ff @(posedge mclk_i) begin
        if (reset_i) begin
            cfg <= `GC_CFG_RESET;
        end else if (apb_write && paddr_i == `GC_CFG_OFS) begin
            cfg <= {26'h0, pwdata_i[5:0]};
        end
    end
endmodule : gate_and_output_command_handler

// ===== verif/gate_cmd_chk.sv
// port assertions for the gate and switching port command handler
// assumes the bind below; one clock, checks quiet during reset
`timescale 1ns/10ps
`include "gate_cmd_cfg.svh"
module gate_cmd_chk (
    // clock and reset
    input wire logic mclk_i,
    input wire logic reset_i,
    // watched
    input wire logic psel_i,
    input wire logic pwrite_i,
    input wire logic rx_ready_o,
    input wire logic tx_ready_i,
    input wire logic [7:0] tx_data_o,
    input wire logic tx_valid_o,
    input wire logic quality_met_i,
    input wire logic timeout_i,
    input wire logic scan_limit_i,
    input wire logic decode_en_o,
    input wire logic no_read_result_o,
    input wire logic [1:0] pin_i,
    input wire logic [1:0] pin_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (reset_i);
    logic [2:0] quiet;
    logic [1:0] pin_q;
    // cycles since anything that may legally move the gate or the pins
    always_ff @(posedge mclk_i) begin
        pin_q <= pin_i;
        if (reset_i || quality_met_i || timeout_i || scan_limit_i || !rx_ready_o
            || (psel_i && pwrite_i) || pin_i != pin_q) begin
            quiet <= 3'h0;
        end else if (quiet != 3'h7) begin
            quiet <= quiet + 3'h1;
        end
    end
    a_decode_open: assert property ($rose(decode_en_o) |->
        !$past(rx_ready_o, 1) || !$past(rx_ready_o, 2) || !$past(rx_ready_o, 3))
        else $error("gate opened without a command");
    a_gate_holds: assert property ($fell(decode_en_o) |-> quiet < 3'h6)
        else $error("gate closed without a cause");
    a_no_read_result_gate: assert property (no_read_result_o |->
        $past(decode_en_o, 1) || $past(decode_en_o, 2))
        else $error("no-read result without an open gate");
    a_no_read_result_pulse: assert property (no_read_result_o |=> !no_read_result_o)
        else $error("no-read pulse too long");
    a_close_gate: assert property (no_read_result_o |-> ##[0:2] !decode_en_o)
        else $error("gate still open after close");
    a_no_read_result_reply: assert property (no_read_result_o |->
        ##[0:8] (tx_valid_o && tx_data_o == `GC_NO_READ_CHAR))
        else $error("no-read result not sent");
    a_tx_hold: assert property (tx_valid_o && !tx_ready_i |=>
        tx_valid_o && $stable(tx_data_o))
        else $error("reply byte dropped while stalled");
    a_rx_busy: assert property (tx_valid_o |-> !rx_ready_o)
        else $error("command taken during reply");
    a_pins_cause: assert property ($changed(pin_o) |-> quiet < 3'h6)
        else $error("pin moved without a command");
endmodule : gate_cmd_chk

bind gate_and_output_command_handler gate_cmd_chk i_chk (.mclk_i, .reset_i, .psel_i,
    .pwrite_i, .rx_ready_o, .tx_ready_i, .tx_data_o, .tx_valid_o, .quality_met_i,
    .timeout_i, .scan_limit_i, .decode_en_o, .no_read_result_o, .pin_i, .pin_o);

// ===== verif/host_model.sv
// host controller model: sends one command line, collects the reply line
// assumes the byte handshake of the handler; slow makes it stall replies
`timescale 1ns/10ps
module host_model (
    // clock
    input wire logic mclk_i,
    // commands out
    output logic [7:0] rx_data_o,
    output logic rx_valid_o,
    input wire logic rx_ready_i,
    // replies in
    output logic tx_ready_o,
    input wire logic [7:0] tx_data_i,
    input wire logic tx_valid_i
);
    logic slow = 1'b0;
    initial begin
        rx_data_o = 8'h00;
        rx_valid_o = 1'b0;
        tx_ready_o = 1'b0;
    end
    // every set line sent in earnest lists its ports ascending
    task automatic send_line(input string s, output logic [127:0] rep);
        int n;
        logic done;
        rep = '0;
        for (int i = 0; i <= s.len(); i++) begin
            rx_data_o <= (i == s.len()) ? 8'h0D : 8'(s[i]);
            rx_valid_o <= 1'b1;
            do @(posedge mclk_i); while (rx_ready_i !== 1'b1);
        end
        // a released line shows no stale byte
        rx_valid_o <= 1'b0;
        rx_data_o <= ~rx_data_o;
        tx_ready_o <= 1'b1;
        n = 0;
        done = 1'b0;
        while (!done) begin
            @(posedge mclk_i);
            n++;
            if (tx_valid_i === 1'b1 && tx_ready_o === 1'b1) begin
                rep = {rep[119:0], tx_data_i};
                done = (tx_data_i == 8'h0D);
            end
            if ((rep == '0 && n > 12) || n > 200) done = 1'b1;
            tx_ready_o <= done ? 1'b0 : (slow ? ~tx_ready_o : 1'b1);
        end
    endtask : send_line
endmodule : host_model

// ===== verif/tb_gate_and_output_command_handler.sv
// self-checking bench for the gate and switching port command handler
// assumes host_model on the byte link and the bound port checker
`timescale 1ns/10ps
module tb_gate_and_output_command_handler;
    logic mclk_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] paddr = 8'h00;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [7:0] rx_data;
    logic rx_valid;
    logic rx_ready;
    logic tx_ready;
    logic [7:0] tx_data;
    logic tx_valid;
    logic [2:0] cause = 3'h0;
    logic decode_en;
    logic no_read;
    logic [1:0] field = 2'h0;
    logic [1:0] pin_in;
    logic [1:0] pin_out;
    logic [1:0] pin_oe_n;
    logic [127:0] rep;
    logic [31:0] rd;
    logic er;
    int fail_count = 0;
    int n_compared = 0;
    // field wiring follows the pin wherever the port drives it
    assign pin_in = (pin_oe_n & field) | (~pin_oe_n & pin_out);
    gate_and_output_command_handler i_dut (.mclk_i(mclk_i), .reset_i(reset_i),
        .paddr_i(paddr), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
        .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
        .rx_data_i(rx_data), .rx_valid_i(rx_valid), .rx_ready_o(rx_ready),
        .tx_ready_i(tx_ready), .tx_data_o(tx_data), .tx_valid_o(tx_valid),
        .quality_met_i(cause[0]), .timeout_i(cause[1]), .scan_limit_i(cause[2]),
        .decode_en_o(decode_en), .no_read_result_o(no_read), .pin_i(pin_in),
        .pin_o(pin_out), .pin_oe_n_o(pin_oe_n));
    host_model i_host (.mclk_i(mclk_i), .rx_data_o(rx_data), .rx_valid_o(rx_valid),
        .rx_ready_i(rx_ready), .tx_ready_o(tx_ready), .tx_data_i(tx_data),
        .tx_valid_i(tx_valid));
    initial begin
        forever #5 mclk_i = ~mclk_i;
    end
    task automatic test_done();
        $display("compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : test_done
    task automatic check(input logic [127:0] seen, input logic [127:0] exp);
        n_compared++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    // one transfer, then an idle edge so the next never lands in the same step
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge mclk_i);
        penable <= 1'b1;
        do @(posedge mclk_i); while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge mclk_i);
    endtask : apb
    task automatic cfg(input logic [31:0] d);
        apb(1'b1, 8'h00, d, rd, er);
        repeat (3) @(posedge mclk_i);
    endtask : cfg
    task automatic say(input string s, input logic [127:0] exp);
        i_host.send_line(s, rep);
        check(rep, exp);
    endtask : say
    task automatic t_regs();
        apb(1'b0, 8'h00, 32'h0, rd, er);
        check({er, rd}, 33'h0);
        apb(1'b1, 8'h08, 32'hFFFF_FFFF, rd, er);
        apb(1'b0, 8'h08, 32'h0, rd, er);
        check({er, rd}, 33'h1_0000_0000);
    endtask : t_regs
    task automatic t_gate();
        for (int k = 0; k < 3; k++) begin
            say("+", 128'h0);
            check(decode_en, 1'b1);
            cause <= 3'(1 << k);
            @(posedge mclk_i);
            cause <= 3'h0;
            repeat (4) @(posedge mclk_i);
            check(decode_en, 1'b0);
        end
        cfg(32'h0000_0001);
        say("+", 128'h0);
        field <= 2'h1;
        repeat (6) @(posedge mclk_i);
        check(decode_en, 1'b0);
        field <= 2'h0;
        say("+", 128'h0);
        say("-", {"?", 8'h0D});
        apb(1'b0, 8'h04, 32'h0, rd, er);
        check(rd[0], 1'b0);
        // a close with the gate already shut must stay silent
        say("-", 128'h0);
    endtask : t_gate
    task automatic t_ports();
        cfg(32'h0000_0016);
        check(pin_oe_n, 2'h2);
        check(pin_out, 2'h1);
        say("OA1", 128'h0); // port one is an output by now
        check(pin_out, 2'h0);
        say("OA3", 128'h0);
        check(pin_out, 2'h0);
        say("OA?", {"OA S1=1;S2=I", 8'h0D});
        apb(1'b0, 8'h04, 32'h0, rd, er);
        check(rd, 32'h0000_0002);
        cfg(32'h0000_0012);
        say("OA?", {"OA S1=1;S2=P", 8'h0D});
    endtask : t_ports
    // second line breaks the ascending order on purpose; the fourth overflows
    task automatic t_set();
        string cmds [6] = '{"OA S1=0;S2=1", "OA S2=0;S1=1", "OA S1=5",
                            "OA S1=1;S2=0;S1", "OA S1=1", "OA S2=0"};
        logic [7:0] code [6] = '{"0", "1", "2", "3", "0", "0"};
        logic [1:0] pins [6] = '{2'h2, 2'h2, 2'h2, 2'h2, 2'h3, 2'h1};
        cfg(32'h0000_000A);
        i_host.slow = 1'b1;
        for (int k = 0; k < 6; k++) begin
            say(cmds[k], {"OA=0", code[k], 8'h0D});
            check(pin_out, pins[k]);
        end
        say("OA2", 128'h0);
        check(pin_out, 2'h3);
        cfg(32'h0000_0009);
        say("OA S1=0;S2=1", {"OA=00", 8'h0D});
        say("OA?", {"OA S1=I;S2=1", 8'h0D});
        // port two inverted: logic low drives the pin high, port one keeps its old state
        cfg(32'h0000_0029);
        say("OA S1=0;S2=0", {"OA=00", 8'h0D});
        check(pin_out, 2'h3);
        say("OA?", {"OA S1=I;S2=0", 8'h0D});
    endtask : t_set
    initial begin
        repeat (6) @(posedge mclk_i);
        reset_i <= 1'b0;
        @(posedge mclk_i);
        t_regs();
        t_gate();
        t_ports();
        t_set();
        test_done();
    end
    // the whole run needs a few hundred cycles
    initial begin
        repeat (20000) @(posedge mclk_i);
        fail_count++;
        test_done();
    end
endmodule : tb_gate_and_output_command_handler
